// ===== verilog/isl_regs.svh
// register map, field positions, reset values and counts of the i2c slave
// Notes on behaviour
// - sda falling while scl high is a start; it sets the busy flag
// - after start, seven address bits msb first are compared with own address
// - matching address sets the match flag and raises the interrupt
// - the eighth bit is stored as read/write flag; 1 means master reads
// - on match the slave pulls sda low during the ninth clock
// - data bytes are eight bits, msb first, only after address acknowledge
// - as receiver, the ninth clock carries the software ack bit; 0 acknowledges
// - as transmitter, a missing master ack releases sda until stop
// - after a match scl is held low until data write or dummy read
// - one interrupt for match, byte done or time-out; flags tell cause
// - slave works only with mode field 110 and interface enable set
// - time-out counter starts on start plus match, clears on scl falling
// - time-out fires if period passes before next scl fall; stop halts counting
// - on expiry counter halts, enable clears, flag sets, interrupt is raised
// - expiry resets slave logic and status register; other registers except time-out keep contents
// - period is select plus one times 32 low-speed clock periods
// - time-out register: enable bit 7, flag bit 6, select bits 5..0
// - a stop clears the busy flag
// - byte-done clears during a transfer, sets with interrupt at byte end
`ifndef ISL_REGS_SVH
`define ISL_REGS_SVH

`define ISL_ADDR_MODE 12'h000
`define ISL_ADDR_STAT 12'h004
`define ISL_ADDR_OWN 12'h008
`define ISL_ADDR_DATA 12'h00c
`define ISL_ADDR_TOC 12'h010
`define ISL_ADDR_IEN 12'h014

`define ISL_MODE_RST 3'h7
`define ISL_MODE_I2C 3'h6
`define ISL_MODE_HI 7
`define ISL_MODE_LO 5
`define ISL_MODE_EN 1

`define ISL_ST_BDONE 7
`define ISL_ST_MATCH 6
`define ISL_ST_BUSY 5
`define ISL_ST_TXDIR 4
`define ISL_ST_ACKTX 3
`define ISL_ST_RW 2
`define ISL_ST_ACKRX 0

`define ISL_TOC_EN 7
`define ISL_TOC_FLAG 6
`define ISL_TOC_SEL_HI 5
`define ISL_TOC_SEL_LO 0

`define ISL_IEN_SIE 0

`define ISL_BITS 4'h8
`define ISL_TX_LAST 4'h7
`define ISL_TO_PRE_LAST 5'h1f

`endif

// ===== verilog/isl_pkg.sv
// types shared by the i2c slave files
package isl_pkg;

    typedef enum logic [3:0] {
        PH_IDLE,
        PH_ADDR,
        PH_AACK,
        PH_HOLD,
        PH_RX,
        PH_RACK,
        PH_TX,
        PH_TACK,
        PH_WAIT
    } isl_phase_e;

    typedef struct packed {
        isl_phase_e st;
        logic [3:0] cnt;
        logic [7:0] shft;
        logic [7:0] data;
        logic scl_d;
        logic sda_d;
        logic lsc_d;
        logic sda_oe;
        logic scl_oe;
        logic [2:0] mode;
        logic en;
        logic busy;
        logic match;
        logic rw;
        logic byte_done;
        logic txdir;
        logic ack_tx;
        logic ack_rx;
        logic [7:0] own;
        logic to_en;
        logic to_flag;
        logic [5:0] to_sel;
        logic sie;
        logic to_run;
        logic [4:0] pre;
        logic [5:0] units;
        logic irq;
        logic [7:0] rdata;
    } isl_state_s;

endpackage

// ===== verilog/isl_sync.sv
// two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module isl_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } isl_sync_s;

    isl_sync_s r;
    isl_sync_s d;

    // first stage feeds only the second
    always_comb begin
        d.meta = din;
        d.sync = r.meta;
    end

    // reset high: idle bus lines read high, so no false edge at release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '1;
        end else begin
            r <= d;
        end
    end

    assign dout = r.sync;
endmodule

// ===== verilog/isl_slave.sv
// i2c slave engine with apb registers and bus time-out
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "isl_regs.svh"
module isl_slave (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic low_speed_clock,
    output logic serial_irq
);
    localparam isl_pkg::isl_state_s RST = '{
        st: isl_pkg::PH_IDLE,
        mode: `ISL_MODE_RST,
        byte_done: 1'b1,
        ack_rx: 1'b1,
        scl_d: 1'b1,
        sda_d: 1'b1,
        lsc_d: 1'b1, // synchroniser resets high, so no false slow-clock edge
        default: '0
    };

    isl_pkg::isl_state_s r;
    isl_pkg::isl_state_s d;

    logic [2:0] sync_out;
    logic s_scl;
    logic s_sda;
    logic s_lsc;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic lsc_rise;
    logic active;
    logic quiet;
    logic to_exp;
    logic addr_eq;
    logic setup;
    logic acc;
    logic wr;
    logic rd_acc;
    logic hit;

    // pins and the low-speed clock come from outside this domain
    isl_sync #(
        .W(3)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .din({low_speed_clock, sda_in, scl_in}),
        .dout(sync_out)
    );

    assign s_scl = sync_out[0];
    assign s_sda = sync_out[1];
    assign s_lsc = sync_out[2];

    // bus edges and conditions from synchronised levels
    assign scl_rise = s_scl & ~r.scl_d;
    assign scl_fall = ~s_scl & r.scl_d;
    assign start_ev = s_scl & r.scl_d & ~s_sda & r.sda_d;
    assign stop_ev = s_scl & r.scl_d & s_sda & ~r.sda_d;
    assign lsc_rise = s_lsc & ~r.lsc_d;

    // slave only runs in i2c slave mode with the interface enabled
    assign active = (r.mode == `ISL_MODE_I2C) & r.en;
    assign addr_eq = (r.shft[7:1] == r.own[7:1]);

    // counter unit is 32 low-speed periods; expiry after select+1 units
    assign to_exp = r.to_run & r.to_en & lsc_rise & ~scl_fall
        & (r.pre == `ISL_TO_PRE_LAST) & (r.units == r.to_sel);
    assign quiet = active & ~start_ev & ~stop_ev & ~to_exp;

    // apb phases; zero wait states, read data fetched in the setup cycle
    assign setup = psel & ~penable;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd_acc = acc & ~pwrite;

    always_comb begin
        if (paddr == `ISL_ADDR_MODE) begin
            hit = 1'b1;
        end else if (paddr == `ISL_ADDR_STAT) begin
            hit = 1'b1;
        end else if (paddr == `ISL_ADDR_OWN) begin
            hit = 1'b1;
        end else if (paddr == `ISL_ADDR_DATA) begin
            hit = 1'b1;
        end else if (paddr == `ISL_ADDR_TOC) begin
            hit = 1'b1;
        end else if (paddr == `ISL_ADDR_IEN) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // next state: bus access first, then the engine, then time-out on top
    always_comb begin
        d = r;
        d.irq = 1'b0;
        d.scl_d = s_scl;
        d.sda_d = s_sda;
        d.lsc_d = s_lsc;

        // read mux, captured so prdata comes from a flop
        if (setup && !pwrite) begin
            d.rdata = 8'h00;
            if (paddr == `ISL_ADDR_MODE) begin
                d.rdata[`ISL_MODE_HI:`ISL_MODE_LO] = r.mode;
                d.rdata[`ISL_MODE_EN] = r.en;
            end else if (paddr == `ISL_ADDR_STAT) begin
                d.rdata[`ISL_ST_BDONE] = r.byte_done;
                d.rdata[`ISL_ST_MATCH] = r.match;
                d.rdata[`ISL_ST_BUSY] = r.busy;
                d.rdata[`ISL_ST_TXDIR] = r.txdir;
                d.rdata[`ISL_ST_ACKTX] = r.ack_tx;
                d.rdata[`ISL_ST_RW] = r.rw;
                d.rdata[`ISL_ST_ACKRX] = r.ack_rx;
            end else if (paddr == `ISL_ADDR_OWN) begin
                d.rdata = r.own;
            end else if (paddr == `ISL_ADDR_DATA) begin
                d.rdata = r.data;
            end else if (paddr == `ISL_ADDR_TOC) begin
                d.rdata[`ISL_TOC_EN] = r.to_en;
                d.rdata[`ISL_TOC_FLAG] = r.to_flag;
                d.rdata[`ISL_TOC_SEL_HI:`ISL_TOC_SEL_LO] = r.to_sel;
            end else if (paddr == `ISL_ADDR_IEN) begin
                d.rdata[`ISL_IEN_SIE] = r.sie;
            end
        end

        // register writes take effect at the access edge
        if (wr) begin
            if (paddr == `ISL_ADDR_MODE) begin
                d.mode = pwdata[`ISL_MODE_HI:`ISL_MODE_LO];
                d.en = pwdata[`ISL_MODE_EN];
            end else if (paddr == `ISL_ADDR_STAT) begin
                d.txdir = pwdata[`ISL_ST_TXDIR];
                d.ack_tx = pwdata[`ISL_ST_ACKTX];
            end else if (paddr == `ISL_ADDR_OWN) begin
                d.own = pwdata[7:0];
            end else if (paddr == `ISL_ADDR_DATA) begin
                d.data = pwdata[7:0];
                // transmit load releases the stretched clock, msb goes out first
                if (r.st == isl_pkg::PH_HOLD && r.txdir) begin
                    d.shft = pwdata[7:0];
                    d.cnt = 4'h0;
                    d.st = isl_pkg::PH_TX;
                    d.scl_oe = 1'b0;
                    d.sda_oe = ~pwdata[7];
                    d.byte_done = 1'b0;
                end
            end else if (paddr == `ISL_ADDR_TOC) begin
                d.to_en = pwdata[`ISL_TOC_EN];
                // writing 0 clears the flag, writing 1 leaves it
                d.to_flag = r.to_flag & pwdata[`ISL_TOC_FLAG];
                d.to_sel = pwdata[`ISL_TOC_SEL_HI:`ISL_TOC_SEL_LO];
            end else if (paddr == `ISL_ADDR_IEN) begin
                d.sie = pwdata[`ISL_IEN_SIE];
            end
        end

        // dummy read of data in receive mode releases the clock
        if (rd_acc && paddr == `ISL_ADDR_DATA) begin
            if (r.st == isl_pkg::PH_HOLD && !r.txdir) begin
                d.st = isl_pkg::PH_RX;
                d.cnt = 4'h0;
                d.scl_oe = 1'b0;
                d.byte_done = 1'b0;
            end
        end

        // protocol engine; start and stop override any phase
        if (!active) begin
            d.st = isl_pkg::PH_IDLE;
            d.busy = 1'b0;
            d.match = 1'b0;
            d.rw = 1'b0;
            d.byte_done = 1'b1;
            d.ack_rx = 1'b1;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
            d.to_run = 1'b0;
        end else if (start_ev) begin
            d.busy = 1'b1;
            d.st = isl_pkg::PH_ADDR;
            d.cnt = 4'h0;
            d.match = 1'b0;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
        end else if (stop_ev) begin
            d.busy = 1'b0;
            d.st = isl_pkg::PH_IDLE;
            d.to_run = 1'b0;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
        end else begin
            case (r.st)
                isl_pkg::PH_ADDR: begin
                    // address and direction bit, msb first
                    if (scl_rise) begin
                        d.shft = {r.shft[6:0], s_sda};
                        d.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == `ISL_BITS) begin
                        if (addr_eq) begin
                            d.match = 1'b1;
                            d.rw = r.shft[0];
                            d.irq = 1'b1;
                            d.sda_oe = 1'b1;
                            d.to_run = 1'b1;
                            d.st = isl_pkg::PH_AACK;
                        end else begin
                            d.st = isl_pkg::PH_WAIT;
                        end
                    end
                end
                isl_pkg::PH_AACK: begin
                    // end of ninth clock: free sda, stretch scl for software
                    if (scl_fall) begin
                        d.sda_oe = 1'b0;
                        d.scl_oe = 1'b1;
                        d.st = isl_pkg::PH_HOLD;
                    end
                end
                isl_pkg::PH_RX: begin
                    if (scl_rise) begin
                        d.shft = {r.shft[6:0], s_sda};
                        d.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == `ISL_BITS) begin
                        d.data = r.shft;
                        d.byte_done = 1'b1;
                        d.irq = 1'b1;
                        d.sda_oe = ~r.ack_tx;
                        d.st = isl_pkg::PH_RACK;
                    end
                end
                isl_pkg::PH_RACK: begin
                    // hold the clock again until the byte is read
                    if (scl_fall) begin
                        d.sda_oe = 1'b0;
                        d.scl_oe = 1'b1;
                        d.st = isl_pkg::PH_HOLD;
                    end
                end
                isl_pkg::PH_TX: begin
                    // next bit changes only while scl is low
                    if (scl_fall) begin
                        if (r.cnt == `ISL_TX_LAST) begin
                            d.sda_oe = 1'b0;
                            d.st = isl_pkg::PH_TACK;
                        end else begin
                            d.shft = {r.shft[6:0], 1'b0};
                            d.cnt = r.cnt + 4'h1;
                            d.sda_oe = ~r.shft[6];
                        end
                    end
                end
                isl_pkg::PH_TACK: begin
                    if (scl_rise) begin
                        d.ack_rx = s_sda;
                        d.byte_done = 1'b1;
                        d.irq = 1'b1;
                    end else if (scl_fall) begin
                        if (r.ack_rx) begin
                            d.st = isl_pkg::PH_WAIT;
                        end else begin
                            d.scl_oe = 1'b1;
                            d.st = isl_pkg::PH_HOLD;
                        end
                    end
                end
                default: begin
                    // idle and wait: nothing moves until start or stop; hold ends on data write or dummy read
                end
            endcase
        end

        // time-out prescaler and period counter, cleared by scl falling
        if (scl_fall) begin
            d.pre = 5'h00;
            d.units = 6'h00;
        end else if (r.to_run && r.to_en && lsc_rise) begin
            if (r.pre == `ISL_TO_PRE_LAST) begin
                d.pre = 5'h00;
                d.units = r.units + 6'h01;
            end else begin
                d.pre = r.pre + 5'h01;
            end
        end

        // expiry resets engine and status; data, address, mode are kept
        if (to_exp) begin
            d.st = isl_pkg::PH_IDLE;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
            d.byte_done = RST.byte_done;
            d.match = RST.match;
            d.busy = RST.busy;
            d.txdir = RST.txdir;
            d.ack_tx = RST.ack_tx;
            d.rw = RST.rw;
            d.ack_rx = RST.ack_rx;
            d.to_run = 1'b0;
            d.to_en = 1'b0;
            d.to_flag = 1'b1; // set wins over a clearing write
            d.pre = 5'h00;
            d.units = 6'h00;
            d.irq = 1'b1;
        end

        // one interrupt line for all three causes, gated by the enable
        d.irq = d.irq & r.sie;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= RST;
        end else begin
            r <= d;
        end
    end

    // open-drain pins: data lines are only ever pulled low
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe = r.sda_oe;
    assign scl_oe = r.scl_oe;
    assign serial_irq = r.irq;
    assign prdata = {24'h000000, r.rdata};
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_addr_done;
        quiet && r.st == isl_pkg::PH_ADDR && scl_fall && r.cnt == `ISL_BITS && addr_eq;
    endsequence

    sequence s_rx_done;
        quiet && r.st == isl_pkg::PH_RX && scl_fall && r.cnt == `ISL_BITS;
    endsequence

    sequence s_tx_load;
        quiet && wr && paddr == `ISL_ADDR_DATA && r.st == isl_pkg::PH_HOLD && r.txdir;
    endsequence

    property p_start_busy;
        active && start_ev && !to_exp |=> r.busy && r.st == isl_pkg::PH_ADDR;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start did not set busy");

    property p_stop_free;
        active && stop_ev && !to_exp |=> !r.busy && r.st == isl_pkg::PH_IDLE && !r.to_run;
    endproperty
    a_stop_free: assert property (p_stop_free) else $error("stop did not free bus");

    property p_match;
        s_addr_done |=> r.match && r.to_run && serial_irq == $past(r.sie);
    endproperty
    a_match: assert property (p_match) else $error("address match not flagged");

    property p_rw;
        s_addr_done |=> r.rw == $past(r.shft[0]);
    endproperty
    a_rw: assert property (p_rw) else $error("direction bit not stored");

    property p_addr_ack;
        s_addr_done |=> r.sda_oe ##1 (r.sda_oe || $past(scl_fall) || !$past(quiet));
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address ack not driven");

    property p_hold;
        r.st == isl_pkg::PH_HOLD |-> r.scl_oe && !r.sda_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("scl not held while waiting");

    property p_rx_ack;
        s_rx_done |=> r.sda_oe == !$past(r.ack_tx) && r.byte_done && r.data == $past(r.shft);
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("receive ack wrong");

    property p_nack;
        quiet && r.st == isl_pkg::PH_TACK && scl_fall && r.ack_rx
            |=> r.st == isl_pkg::PH_WAIT && !r.sda_oe && !r.scl_oe;
    endproperty
    a_nack: assert property (p_nack) else $error("nack did not release sda");

    property p_tx_msb;
        s_tx_load |=> r.st == isl_pkg::PH_TX && r.sda_oe == !$past(pwdata[7]) && !r.scl_oe;
    endproperty
    a_tx_msb: assert property (p_tx_msb) else $error("transmit msb wrong");

    property p_timeout;
        to_exp |=> r.to_flag && !r.to_en && !r.busy && r.byte_done && r.st == isl_pkg::PH_IDLE;
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out effects missing");

    property p_inactive;
        !active |=> r.st == isl_pkg::PH_IDLE && !r.sda_oe && !r.scl_oe;
    endproperty
    a_inactive: assert property (p_inactive) else $error("disabled slave active");
endmodule

// ===== verification/isl_master.sv
// bus master model: open drain, honours clock stretching
`timescale 1ns/1ns
module isl_master (
    input wire logic scl,
    input wire logic sda,
    output logic scl_pull,
    output logic sda_pull
);
    // idle bus: both lines left to the pull-ups
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // release scl, then wait out any stretch by the slave
    task automatic rise();
        scl_pull = 1'b0;
        wait (scl === 1'b1);
        #40;
    endtask
    // only the master makes a start
    task automatic start();
        sda_pull = 1'b1;
        #80;
        scl_pull = 1'b1;
    endtask
    // sda rises while scl is high
    task automatic stop();
        #60;
        sda_pull = 1'b1;
        #20;
        rise();
        sda_pull = 1'b0;
        #200;
    endtask
    // data set late in the low phase, so the slave keeps its hold time
    task automatic bit_io(input logic b, output logic r);
        #60;
        sda_pull = !b;
        #20;
        rise();
        r = sda;
        #40;
        scl_pull = 1'b1;
    endtask
    // eight bits msb first, then the ack slot
    task automatic xfer(input logic [7:0] tx, input logic ak_in, output logic [7:0] rx,
        output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ak_in, ak);
    endtask
endmodule

// ===== verification/isl_slave_tb.sv
// self-checking bench: apb software side against the bus master model
`timescale 1ns/1ns
`include "isl_regs.svh"
module isl_slave_tb;
    localparam int TO_CYC = (1 + 1) * 32 * 20;
    logic clk = 1'b0, reset_n = 1'b0, lsc = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, serial_irq, m_scl, m_sda, ak;
    wire scl = !((scl_oe && !scl_out) || m_scl);
    wire sda = !((sda_oe && !sda_out) || m_sda);
    int failures = 0, check_count = 0, cycles = 0, n, seed = 18852;
    logic [15:0] exp_q[$];
    logic [6:0] own;
    logic [7:0] d1, d2, d3, rx;
    logic [7:0] por [6] = '{8'he0, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00};

    always #5 clk = ~clk;
    always #100 lsc = ~lsc;

    isl_slave u_isl_slave (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .low_speed_clock(lsc), .serial_irq(serial_irq));
    isl_master u_isl_master (.scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one apb transfer; the request stands until pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // note the expected value and mask, then read
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({e & m, m});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // bounded wait for the interrupt pulse, k counts the cycles
    task automatic wait_irq(output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (serial_irq !== 1'b1 && k < 5000);
        if (k >= 5000) chk("serial_irq", 8'h01, 8'h00);
    endtask

    // read watcher takes the oldest note at each completed read
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk("prdata", exp_q[0][15:8], prdata[7:0] & exp_q[0][7:0]);
            chk("pslverr", {7'h00, paddr == 12'h018}, {7'h00, pslverr});
            void'(exp_q.pop_front());
        end
    end
    // hang guard, well above the length of the sequence below
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(12'(i * 4), por[i], 8'hff);
        end
        rd(12'h018, 8'h00, 8'hff);
        own = 7'($random(seed));
        d1 = 8'($random(seed));
        d2 = ~d1;
        d3 = 8'($random(seed));
        apb(1'b1, `ISL_ADDR_MODE, 32'h0000_00c2);
        apb(1'b1, `ISL_ADDR_OWN, {24'h0, own, 1'b0});
        apb(1'b1, `ISL_ADDR_IEN, 32'h0000_0001);
        // write of two bytes, the second refused through ack_to_send
        fork
            begin
                u_isl_master.start();
                u_isl_master.xfer({own, 1'b0}, 1'b1, rx, ak);
                chk("addr_ack", 8'h00, {7'h00, ak});
                u_isl_master.xfer(d1, 1'b1, rx, ak);
                chk("ack_bit", 8'h00, {7'h00, ak});
                u_isl_master.xfer(d2, 1'b1, rx, ak);
                chk("nack_bit", 8'h01, {7'h00, ak});
                u_isl_master.stop();
            end
            begin
                wait_irq(n);
                rd(`ISL_ADDR_STAT, 8'h60, 8'h64);
                repeat (40) @(posedge clk);
                chk("scl_held", 8'h00, {7'h00, scl});
                rd(`ISL_ADDR_DATA, 8'h00, 8'h00);
                wait_irq(n);
                // a data access only frees scl once the ninth clock is over
                repeat (40) @(posedge clk);
                apb(1'b1, `ISL_ADDR_STAT, 32'h0000_0008);
                rd(`ISL_ADDR_DATA, d1, 8'hff);
                wait_irq(n);
                repeat (40) @(posedge clk);
                rd(`ISL_ADDR_DATA, d2, 8'hff);
            end
        join
        rd(`ISL_ADDR_STAT, 8'h00, 8'h20);
        // a foreign address gets no acknowledge
        u_isl_master.start();
        u_isl_master.xfer({~own, 1'b0}, 1'b1, rx, ak);
        chk("foreign_ack", 8'h01, {7'h00, ak});
        u_isl_master.stop();
        // read of one byte, ended by a master nack
        fork
            begin
                u_isl_master.start();
                u_isl_master.xfer({own, 1'b1}, 1'b1, rx, ak);
                u_isl_master.xfer(8'hff, 1'b1, rx, ak);
                chk("tx_byte", d3, rx);
                u_isl_master.stop();
            end
            begin
                wait_irq(n);
                rd(`ISL_ADDR_STAT, 8'h64, 8'h64);
                apb(1'b1, `ISL_ADDR_STAT, 32'h0000_0010);
                repeat (40) @(posedge clk);
                apb(1'b1, `ISL_ADDR_DATA, {24'h0, d3});
                wait_irq(n);
                rd(`ISL_ADDR_STAT, 8'h81, 8'h81);
            end
        join
        rd(`ISL_ADDR_STAT, 8'h00, 8'h20);
        // stalled transfer runs into the time-out, select 1
        apb(1'b1, `ISL_ADDR_TOC, 32'h0000_0081);
        fork
            begin
                u_isl_master.start();
                u_isl_master.xfer({own, 1'b0}, 1'b1, rx, ak);
                u_isl_master.stop();
            end
            begin
                wait_irq(n);
                wait_irq(n);
                chk("to_span", 8'h01, {7'h00, n > TO_CYC - 20 && n < TO_CYC + 50});
                rd(`ISL_ADDR_TOC, 8'h41, 8'hff);
                rd(`ISL_ADDR_STAT, 8'h81, 8'hff);
                rd(`ISL_ADDR_OWN, {own, 1'b0}, 8'hff);
                apb(1'b1, `ISL_ADDR_TOC, 32'h0000_0000);
                rd(`ISL_ADDR_TOC, 8'h00, 8'hff);
            end
        join
        tally_and_finish();
    end
endmodule
